// ==== apb_host.sv ====
// apb host model issuing single register transfers
`timescale 1ns/1ns
module apb_host (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [5:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // one transfer, held until pready
  task xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule

// ==== uart_status_flow_control_regs_tb.sv ====
// bench of the status block
`timescale 1ns/1ns
`include "uart_status_map.svh"
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module uart_status_flow_control_regs_tb;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, e;
  logic cts_n, dsr_n, ri_n, cd_n, rts_n, rx_push, rx_push_err, rx_pop, rx_pop_err;
  logic rx_char_valid, rx_store, rx_trigger_hit, tx_busy, tx_enable, tx_flow_send;
  logic tx_flow_stop, tx_flow_ready, tx_flow_valid, baud16_tick, baud_tick;
  logic modem_irq, special_irq;
  logic [5:0] paddr, rx_level, rx_trigger, rx_step;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] rx_line_bits;
  logic [7:0] rx_char, tx_flow_char, q, s1, s2;
  logic [7:0] seen[$], want[$];
  int mismatches = 0, comparisons = 0, cyc = 0;
  // arbitrary ids
  uart_status_regs #(.IDENTITY_CODE(8'h3C), .REVISION_CODE(8'hC3)) dut (.*);
  apb_host host (.*);
  always #5 pclk = ~pclk;
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task rc(input logic [5:0] a, input logic [7:0] x, input string n);
    host.xfer(1'b0, a, 8'h00, q, e);
    `CHK(n, x, q)
  endtask
  task ms;
    host.xfer(1'b0, `ADDR_MODEM_STATUS, 8'h00, q, e);
  endtask
  // one received char, store flag to e
  task rxc(input logic [7:0] c);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    tick(1);
    rx_char_valid <= 1'b0;
    tick(1);
    e = rx_store;
  endtask
  // cycles between two baud ticks
  task baud(input int x);
    int n;
    n = 0;
    do @(posedge pclk); while (baud_tick !== 1'b1);
    do begin @(posedge pclk); n++; end while (baud_tick !== 1'b1);
    `CHK("baud gap", x, n)
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {cts_n, dsr_n, ri_n, cd_n, tx_flow_ready, tx_flow_stop} = 6'h3F;
    {rx_push, rx_push_err, rx_pop, rx_pop_err, rx_char_valid, tx_busy, tx_flow_send} = 7'h0;
    rx_char = 8'h00;
    rx_line_bits = 7'h00;
    {rx_level, rx_trigger, rx_step} = {6'h00, 6'h08, 6'h04};
    r = 32'hCE9AAD2A;
    tick(16);
    presetn <= 1'b1;
    rc(`ADDR_SCRATCH, 8'hFF, "scratch");
    rc(`ADDR_DIVISOR_LOW, 8'h01, "div low");
    `CHK("rts_n", 1'b1, rts_n)
    wr(`ADDR_DIVISOR_LOW, 8'h00);
    rc(`ADDR_IDENTITY, 8'h3C, "identity");
    host.xfer(1'b0, 6'h02, 8'h00, q, e);
    `CHK("slverr", 1'b1, e)
    repeat (4) begin
      r = lfsr(r);
      wr(`ADDR_SCRATCH, r[7:0]);
      rc(`ADDR_SCRATCH, r[7:0], "scratch");
    end
    // protected bits: lock and reset
    wr(`ADDR_MODEM_CONTROL, 8'hFF);
    rc(`ADDR_MODEM_CONTROL, 8'h1B, "modem ctl");
    wr(`ADDR_ENHANCED, 8'h10);
    wr(`ADDR_MODEM_CONTROL, 8'hFF);
    wr(`ADDR_INT_ENABLE, 8'hF0);
    wr(`ADDR_ENHANCED, 8'h00);
    wr(`ADDR_MODEM_CONTROL, 8'h00);
    rc(`ADDR_MODEM_CONTROL, 8'hE4, "modem ctl");
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rc(`ADDR_MODEM_CONTROL, 8'h00, "modem ctl");
    rc(`ADDR_INT_ENABLE, 8'h00, "int enable");
    $display("test registers done");
    // status nibble follows the pins, deltas and ring edge
    repeat (4) begin
      r = lfsr(r);
      {cd_n, ri_n, dsr_n, cts_n} <= r[3:0];
      tick(4);
      ms();
      rc(`ADDR_MODEM_STATUS, {~r[3:0], 4'h0}, "modem st");
    end
    {cd_n, ri_n, dsr_n, cts_n} <= 4'h0;
    wr(`ADDR_INT_ENABLE, 8'h08);
    ms();
    {cd_n, dsr_n, cts_n} <= 3'h7;
    tick(4);
    `CHK("modem irq", 1'b1, modem_irq)
    rc(`ADDR_MODEM_STATUS, 8'h4B, "deltas");
    tick(2);
    `CHK("modem irq", 1'b0, modem_irq)
    ri_n <= 1'b1;
    tick(4);
    rc(`ADDR_MODEM_STATUS, 8'h04, "ring end");
    ri_n <= 1'b0;
    tick(4);
    rc(`ADDR_MODEM_STATUS, 8'h40, "ring start");
    wr(`ADDR_ENHANCED, 8'h10);
    repeat (4) begin
      r = lfsr(r);
      wr(`ADDR_MODEM_CONTROL, {4'h1, r[3:0]});
      ms();
      rc(`ADDR_MODEM_STATUS, {r[3:2], r[0], r[1], 4'h0}, "loop st");
    end
    $display("test modem done");
    // manual and automatic request and clear to send
    wr(`ADDR_MODEM_CONTROL, 8'h02);
    tick(2);
    `CHK("rts_n", 1'b0, rts_n)
    wr(`ADDR_ENHANCED, 8'h40);
    rx_level <= 6'h0C;
    tick(3);
    `CHK("rts_n", 1'b1, rts_n)
    rx_level <= 6'h08;
    tick(3);
    `CHK("rts_n", 1'b1, rts_n)
    `CHK("trig hit", 1'b1, rx_trigger_hit)
    rx_level <= 6'h03;
    tick(3);
    `CHK("rts_n", 1'b0, rts_n)
    tx_busy <= 1'b1;
    wr(`ADDR_ENHANCED, 8'h80);
    `CHK("tx enable", 1'b1, tx_enable)
    tx_busy <= 1'b0;
    tick(3);
    `CHK("tx enable", 1'b0, tx_enable)
    cts_n <= 1'b0;
    tick(4);
    `CHK("tx enable", 1'b1, tx_enable)
    wr(`ADDR_DIVISOR_LOW, 8'h03);
    baud(48);
    wr(`ADDR_ENHANCED, 8'h10);
    wr(`ADDR_MODEM_CONTROL, 8'h80);
    baud(192);
    $display("test flow pins done");
    // special char, then flow chars per mode
    {s1, s2} = r[23:8];
    wr(`ADDR_STOP_CHAR_1, s1);
    wr(`ADDR_STOP_CHAR_2, s2);
    rc(`ADDR_STOP_CHAR_2, 8'h00, "stop char");
    wr(`ADDR_ENHANCED, 8'h20);
    rxc(s2);
    `CHK("store", 1'b1, e)
    wr(`ADDR_ENHANCED, 8'h00);
    wr(`ADDR_ENHANCED, 8'h31);
    wr(`ADDR_INT_ENABLE, 8'h20);
    rxc(s2);
    `CHK("store", 1'b0, e)
    host.xfer(1'b0, `ADDR_INT_STATUS, 8'h00, q, e);
    `CHK("int status", 2'b11, q[5:4])
    `CHK("special irq", 1'b1, special_irq)
    for (int m = 1; m < 4; m++) begin
      wr(`ADDR_ENHANCED, 8'h00);
      wr(`ADDR_ENHANCED, {4'h0, 2'(m), 2'b00});
      tx_flow_send <= 1'b1;
      tick(1);
      tx_flow_send <= 1'b0;
      seen = {};
      want = {};
      repeat (6) begin
        tick(1);
        if (tx_flow_valid && tx_flow_ready) seen.push_back(tx_flow_char);
        tx_flow_ready <= ~tx_flow_ready;
      end
      if (m != 1) want.push_back(s1);
      if (m != 2) want.push_back(s2);
      `CHK("flow count", want.size(), seen.size())
      foreach (want[i]) if (i < seen.size()) `CHK("flow char", want[i], seen[i])
    end
    $display("test characters done");
    // error summary follows flagged bytes in the queue
    rx_line_bits <= r[6:0];
    {rx_push, rx_push_err} <= 2'b11;
    tick(1);
    rx_push_err <= 1'b0;
    tick(1);
    rx_push <= 1'b0;
    rc(`ADDR_LINE_STATUS, {1'b1, r[6:0]}, "line st");
    {rx_pop, rx_pop_err} <= 2'b11;
    tick(1);
    {rx_pop, rx_pop_err} <= 2'b00;
    rc(`ADDR_LINE_STATUS, {1'b0, r[6:0]}, "line st");
    $display("test line status done");
    summarize();
  end
endmodule
bind uart_status_regs uart_status_props #(.LEVEL_W(LEVEL_W)) props (.*);

// ==== uart_status_map.svh ====
// register offsets, field positions, reset values and timing counts of the status block
// Notes on behaviour
// [R01] line status top bit flags erroneous queued bytes
// [R02] modem deltas set when cts, dsr, cd change
// [R03] delta ring only on ring input rising
// [R04] modem interrupt when delta set and enabled
// [R05] auto cts halts after current character
// [R06] status bit 4: inverted cts or rts
// [R07] status bit 5: inverted dsr or dtr
// [R08] status bit 6: inverted ring or control bit 2
// [R09] status bit 7: inverted cd or control bit 3
// [R10] scratch byte resets to all ones
// [R11] baud equals clock over sixteen over divisor
// [R12] host zeroes divisor before reading identity
// [R13] feature bits pick transmit and receive pairs
// [R14] dual mode sends and matches two characters
// [R15] host clears flow selects before reprogramming
// [R16] protected bits writable only while unlocked
// [R17] protected bits clear on reset
// [R18] special character sets status bit 4
// [R19] pair two special match skips the queue
// [R20] auto rts follows queue level hysteresis
// [R21] rts manual output when auto disabled
// [R22] four write-only flow character registers
// [R23] control bit 7 divides clock by four
// [R24] reading modem status clears the deltas
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH

// byte addresses, one word each
`define ADDR_LINE_STATUS    6'h00
`define ADDR_MODEM_STATUS   6'h04
`define ADDR_SCRATCH        6'h08
`define ADDR_DIVISOR_LOW    6'h0C
`define ADDR_DIVISOR_HIGH   6'h10
`define ADDR_IDENTITY       6'h14
`define ADDR_REVISION       6'h18
`define ADDR_ENHANCED       6'h1C
`define ADDR_STOP_CHAR_1    6'h20
`define ADDR_STOP_CHAR_2    6'h24
`define ADDR_RESUME_CHAR_1  6'h28
`define ADDR_RESUME_CHAR_2  6'h2C
`define ADDR_INT_ENABLE     6'h30
`define ADDR_INT_STATUS     6'h34
`define ADDR_FIFO_CONTROL   6'h38
`define ADDR_MODEM_CONTROL  6'h3C

// reset values
`define RST_SCRATCH         8'hFF
`define RST_DIVISOR         16'h0001
`define RST_ZERO            8'h00

// write masks of the protected enhanced bits
`define PROT_INT_ENABLE     8'hF0
`define PROT_INT_STATUS     8'h30
`define PROT_FIFO_CONTROL   8'h30
`define PROT_MODEM_CONTROL  8'hE4

// enhanced feature fields
`define EFR_UNLOCK          4
`define EFR_SPECIAL         5
`define EFR_AUTO_RTS        6
`define EFR_AUTO_CTS        7
// modem control fields
`define MCR_DTR             0
`define MCR_RTS             1
`define MCR_OUT1            2
`define MCR_OUT2            3
`define MCR_LOOP            4
`define MCR_RESUME_ANY      5
`define MCR_PRESCALE        7
// interrupt enable / status fields
`define IER_MODEM           3
`define IER_SPECIAL         5
`define ISR_SPECIAL         4
`define ISR_STOP            5

// flow select codes
`define SEL_NONE            2'b00
`define SEL_PAIR_2          2'b01
`define SEL_PAIR_1          2'b10
`define SEL_BOTH            2'b11

// baud timing
`define PRESCALE_LAST       2'h3
`define OVERSAMPLE_LAST     4'hF

`endif

// ==== uart_status_pkg.sv ====
// types shared by the status and flow control block
package uart_status_pkg;
  typedef enum logic [2:0] {
    FLOW_IDLE   = 3'b001,
    FLOW_FIRST  = 3'b010,
    FLOW_SECOND = 3'b100
  } flow_tx_state_t;
endpackage

// ==== uart_status_props.sv ====
// concurrent checks on the status block ports
`timescale 1ns/1ns
module uart_status_props #(
  parameter int LEVEL_W = 6
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb handshake
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  // receive side
  input wire logic               rx_char_valid,
  input wire logic               rx_store,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic [LEVEL_W-1:0] rx_trigger,
  input wire logic               rx_trigger_hit,
  // transmit side and baud
  input wire logic               tx_busy,
  input wire logic               tx_enable,
  input wire logic               tx_flow_ready,
  input wire logic               tx_flow_valid,
  input wire logic [7:0]         tx_flow_char,
  input wire logic               baud_tick
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // transfer steps before the answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_ready_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_store_after_char: assert property (rx_store |-> $past(rx_char_valid))
    else $error("store without char");
  a_halt_between_chars: assert property ($fell(tx_enable) |-> !$past(tx_busy))
    else $error("halt mid char");
  a_flow_char_held: assert property (
    tx_flow_valid && !tx_flow_ready |=> tx_flow_valid && $stable(tx_flow_char))
    else $error("flow char dropped");
  a_baud_gap: assert property (baud_tick |=> !baud_tick [*8])
    else $error("baud ticks too close");
  a_trigger_level: assert property (
    rx_trigger_hit |-> $past(rx_level) >= $past(rx_trigger))
    else $error("trigger hit too low");
endmodule

// ==== uart_status_regs.sv ====
// status, divisor, enhanced feature and flow control registers behind an apb slave
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "uart_status_map.svh"
module uart_status_regs
  import uart_status_pkg::*;
#(
  parameter int  LEVEL_W     = 6,
  parameter logic [7:0] IDENTITY_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [5:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // modem pins, active low
  input  wire logic               cts_n,
  input  wire logic               dsr_n,
  input  wire logic               ri_n,
  input  wire logic               cd_n,
  output logic                    rts_n,
  // receive side
  input  wire logic [6:0]         rx_line_bits,
  input  wire logic               rx_push,
  input  wire logic               rx_push_err,
  input  wire logic               rx_pop,
  input  wire logic               rx_pop_err,
  input  wire logic               rx_char_valid,
  input  wire logic [7:0]         rx_char,
  output logic                    rx_store,
  input  wire logic [LEVEL_W-1:0] rx_level,
  input  wire logic [LEVEL_W-1:0] rx_trigger,
  input  wire logic [LEVEL_W-1:0] rx_step,
  output logic                    rx_trigger_hit,
  // transmit side
  input  wire logic               tx_busy,
  output logic                    tx_enable,
  input  wire logic               tx_flow_send,
  input  wire logic               tx_flow_stop,
  input  wire logic               tx_flow_ready,
  output logic                    tx_flow_valid,
  output logic [7:0]              tx_flow_char,
  // baud and interrupts
  output logic                    baud16_tick,
  output logic                    baud_tick,
  output logic                    modem_irq,
  output logic                    special_irq
);

  // register storage
  logic [7:0]  scratch_reg, enhanced_reg, modem_control_reg, int_enable_reg;
  logic [7:0]  fifo_control_reg, int_status_reg;
  logic [15:0] divisor_reg;
  logic [7:0]  stop_char_1_reg, stop_char_2_reg, resume_char_1_reg, resume_char_2_reg;
  logic [3:0]  delta_reg, status_prev_reg;
  logic        primed_reg;
  logic [LEVEL_W:0] err_count_reg;
  logic        seq_stop_reg, seq_resume_reg, sw_halt_reg;
  logic [1:0]  pre_count_reg;
  logic [15:0] div_count_reg;
  logic [3:0]  over_count_reg;
  flow_tx_state_t flow_state_reg, flow_state_next;
  logic        flow_is_stop_reg;

  // merge write data into a register, protected bits only while unlocked
  function automatic logic [7:0] merge_wr(input logic [7:0] old_val, input logic [7:0] new_val,
                                          input logic [7:0] prot, input logic unlock);
    logic [7:0] m;
    m = unlock ? 8'hFF : ~prot;
    merge_wr = (new_val & m) | (old_val & ~m);
  endfunction

  // single or sequenced character match
  function automatic logic char_match(input logic [1:0] sel, input logic [7:0] ch,
                                      input logic [7:0] c1, input logic [7:0] c2,
                                      input logic pend);
    case (sel)
      `SEL_PAIR_1: char_match = (ch == c1);
      `SEL_PAIR_2: char_match = (ch == c2);
      `SEL_BOTH:   char_match = pend && (ch == c2);
      default:     char_match = 1'b0;
    endcase
  endfunction

  // bus decode; a transfer completes when pready is seen high in access
  logic       xfer, wr_en, rd_en, addr_ok;
  logic [7:0] wdata;
  assign xfer  = psel && penable && pready;
  assign wr_en = xfer && pwrite;
  assign rd_en = xfer && !pwrite;
  assign wdata = pwdata[7:0];
  assign addr_ok = (paddr[1:0] == 2'b00);

  // modem status view, with loopback mapping
  logic [3:0] status_now;
  logic [7:0] modem_status;
  logic       loop;
  assign loop = modem_control_reg[`MCR_LOOP];
  always_comb begin
    // [R06] cts or rts
    status_now[0] = loop ? modem_control_reg[`MCR_RTS]  : ~cts_n;
    // [R07] dsr or dtr
    status_now[1] = loop ? modem_control_reg[`MCR_DTR]  : ~dsr_n;
    // [R08] ring or out1
    status_now[2] = loop ? modem_control_reg[`MCR_OUT1] : ~ri_n;
    // [R09] cd or out2
    status_now[3] = loop ? modem_control_reg[`MCR_OUT2] : ~cd_n;
    modem_status = {status_now, delta_reg};
  end

  // read multiplexer
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = addr_ok;
    case (paddr)
      // [R01] error summary
      `ADDR_LINE_STATUS:   rd_mux = {(err_count_reg != '0), rx_line_bits};
      `ADDR_MODEM_STATUS:  rd_mux = modem_status;
      `ADDR_SCRATCH:       rd_mux = scratch_reg;
      `ADDR_DIVISOR_LOW:   rd_mux = divisor_reg[7:0];
      `ADDR_DIVISOR_HIGH:  rd_mux = divisor_reg[15:8];
      `ADDR_IDENTITY:      rd_mux = IDENTITY_CODE;
      `ADDR_REVISION:      rd_mux = REVISION_CODE;
      `ADDR_ENHANCED:      rd_mux = enhanced_reg;
      `ADDR_INT_ENABLE:    rd_mux = int_enable_reg;
      `ADDR_INT_STATUS:    rd_mux = int_status_reg;
      `ADDR_FIFO_CONTROL:  rd_mux = fifo_control_reg;
      `ADDR_MODEM_CONTROL: rd_mux = modem_control_reg;
      // [R22] flow characters read as zero
      `ADDR_STOP_CHAR_1, `ADDR_STOP_CHAR_2,
      `ADDR_RESUME_CHAR_1, `ADDR_RESUME_CHAR_2: rd_mux = `RST_ZERO;
      default: begin
        rd_mux = `RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= {24'h00_0000, (psel && !pwrite) ? rd_mux : `RST_ZERO};
      pslverr <= psel && penable && !pready && !rd_hit;
    end
  end

  // plain registers, read/write except the write-only flow characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [R10] scratch reset value
      scratch_reg       <= `RST_SCRATCH;
      divisor_reg       <= `RST_DIVISOR;
      enhanced_reg      <= `RST_ZERO;
      stop_char_1_reg   <= `RST_ZERO;
      stop_char_2_reg   <= `RST_ZERO;
      resume_char_1_reg <= `RST_ZERO;
      resume_char_2_reg <= `RST_ZERO;
    end else if (wr_en) begin
      case (paddr)
        `ADDR_SCRATCH:       scratch_reg <= wdata;
        `ADDR_DIVISOR_LOW:   divisor_reg[7:0] <= wdata;
        `ADDR_DIVISOR_HIGH:  divisor_reg[15:8] <= wdata;
        `ADDR_ENHANCED:      enhanced_reg <= wdata;
        // [R22] write-only characters
        `ADDR_STOP_CHAR_1:   stop_char_1_reg <= wdata;
        `ADDR_STOP_CHAR_2:   stop_char_2_reg <= wdata;
        `ADDR_RESUME_CHAR_1: resume_char_1_reg <= wdata;
        `ADDR_RESUME_CHAR_2: resume_char_2_reg <= wdata;
        default: ;
      endcase
    end
  end

  // registers holding protected enhanced bits
  logic unlock;
  assign unlock = enhanced_reg[`EFR_UNLOCK];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [R17] legacy state after reset
      int_enable_reg    <= `RST_ZERO;
      fifo_control_reg  <= `RST_ZERO;
      modem_control_reg <= `RST_ZERO;
    end else if (wr_en) begin
      // [R16] lock protected bits
      case (paddr)
        `ADDR_INT_ENABLE:
          int_enable_reg <= merge_wr(int_enable_reg, wdata, `PROT_INT_ENABLE, unlock);
        `ADDR_FIFO_CONTROL:
          fifo_control_reg <= merge_wr(fifo_control_reg, wdata, `PROT_FIFO_CONTROL, unlock);
        `ADDR_MODEM_CONTROL:
          modem_control_reg <= merge_wr(modem_control_reg, wdata, `PROT_MODEM_CONTROL, unlock);
        default: ;
      endcase
    end
  end

  // receive character comparison
  logic [1:0] rx_sel;
  logic       stop_hit, resume_hit, special_hit, flow_hit;
  assign rx_sel     = enhanced_reg[1:0];
  assign stop_hit   = rx_char_valid &&
                      char_match(rx_sel, rx_char, stop_char_1_reg, stop_char_2_reg, seq_stop_reg);
  assign resume_hit = rx_char_valid &&
                      char_match(rx_sel, rx_char, resume_char_1_reg, resume_char_2_reg,
                                 seq_resume_reg);
  // [R18] special character compare
  assign special_hit = rx_char_valid && enhanced_reg[`EFR_SPECIAL] && (rx_char == stop_char_2_reg);
  // [R19] pair two special match dropped
  assign flow_hit   = stop_hit || resume_hit ||
                      (special_hit && (rx_sel == `SEL_PAIR_2));

  // [R14] sequence tracking and store decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_stop_reg   <= 1'b0;
      seq_resume_reg <= 1'b0;
      rx_store       <= 1'b0;
    end else begin
      if (rx_char_valid) begin
        seq_stop_reg   <= (rx_sel == `SEL_BOTH) && (rx_char == stop_char_1_reg);
        seq_resume_reg <= (rx_sel == `SEL_BOTH) && (rx_char == resume_char_1_reg);
      end
      rx_store <= rx_char_valid && !flow_hit;
    end
  end

  // interrupt status flags; a hardware set wins over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= `RST_ZERO;
    end else begin
      if (wr_en && paddr == `ADDR_INT_STATUS)
        int_status_reg <= merge_wr(int_status_reg, wdata, `PROT_INT_STATUS, unlock) &
                          `PROT_INT_STATUS;
      // [R18] special flag
      if (special_hit)
        int_status_reg[`ISR_SPECIAL] <= 1'b1;
      if (stop_hit)
        int_status_reg[`ISR_STOP] <= 1'b1;
    end
  end

  // [R18] special and stop interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      special_irq <= 1'b0;
    else
      special_irq <= int_enable_reg[`IER_SPECIAL] &&
                     (int_status_reg[`ISR_SPECIAL] || int_status_reg[`ISR_STOP]);
  end

  // [R01] count queued bytes that carry an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_count_reg <= '0;
    else if ((rx_push && rx_push_err) && !(rx_pop && rx_pop_err))
      err_count_reg <= err_count_reg + 1'b1;
    else if (!(rx_push && rx_push_err) && (rx_pop && rx_pop_err) && err_count_reg != '0)
      err_count_reg <= err_count_reg - 1'b1;
  end

  // modem delta flags
  logic md_read;
  assign md_read = rd_en && paddr == `ADDR_MODEM_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_reg       <= 4'h0;
      status_prev_reg <= 4'h0;
      primed_reg      <= 1'b0;
    end else begin
      status_prev_reg <= status_now;
      primed_reg      <= 1'b1;
      // [R24] read clears, a new change wins
      delta_reg <= (md_read ? 4'h0 : delta_reg) | ({4{primed_reg}} & {
        // [R02] cd, ring, dsr, cts changes
        status_now[3] ^ status_prev_reg[3],
        // [R03] ring pin low to high
        status_prev_reg[2] & ~status_now[2],
        status_now[1] ^ status_prev_reg[1],
        status_now[0] ^ status_prev_reg[0]});
    end
  end

  // [R04] modem interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      modem_irq <= 1'b0;
    else
      modem_irq <= int_enable_reg[`IER_MODEM] && (delta_reg != 4'h0);
  end

  // software flow halt from received characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sw_halt_reg <= 1'b0;
    else if (rx_sel == `SEL_NONE)
      sw_halt_reg <= 1'b0;
    else if (stop_hit)
      sw_halt_reg <= 1'b1;
    else if (resume_hit || (rx_char_valid && modem_control_reg[`MCR_RESUME_ANY]))
      sw_halt_reg <= 1'b0;
  end

  // transmit gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_enable <= 1'b1;
    else if (sw_halt_reg && !tx_busy)
      tx_enable <= 1'b0;
    // [R05] auto cts halts once idle
    else if (enhanced_reg[`EFR_AUTO_CTS] && cts_n)
      tx_enable <= tx_busy ? tx_enable : 1'b0;
    else if (!sw_halt_reg)
      tx_enable <= 1'b1;
  end

  // [R20] auto rts hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n          <= 1'b1;
      rx_trigger_hit <= 1'b0;
    end else begin
      rx_trigger_hit <= enhanced_reg[`EFR_AUTO_RTS] && (rx_level >= rx_trigger);
      // [R21] manual output without auto
      if (!modem_control_reg[`MCR_RTS] || !enhanced_reg[`EFR_AUTO_RTS])
        rts_n <= ~modem_control_reg[`MCR_RTS];
      else if ({1'b0, rx_level} >= {1'b0, rx_trigger} + {1'b0, rx_step})
        rts_n <= 1'b1;
      else if ({1'b0, rx_level} + {1'b0, rx_step} < {1'b0, rx_trigger})
        rts_n <= 1'b0;
    end
  end

  // [R13] transmit flow character sequencer
  logic [1:0] tx_sel;
  assign tx_sel = enhanced_reg[3:2];
  always_comb begin
    flow_state_next = flow_state_reg;
    case (flow_state_reg)
      FLOW_IDLE:   if (tx_flow_send && tx_sel != `SEL_NONE) flow_state_next = FLOW_FIRST;
      FLOW_FIRST:  if (tx_flow_ready)
                     flow_state_next = (tx_sel == `SEL_BOTH) ? FLOW_SECOND : FLOW_IDLE;
      FLOW_SECOND: if (tx_flow_ready) flow_state_next = FLOW_IDLE;
      default:     flow_state_next = FLOW_IDLE;
    endcase
  end

  // [R14] first then second character of a pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_state_reg   <= FLOW_IDLE;
      flow_is_stop_reg <= 1'b0;
      tx_flow_valid    <= 1'b0;
      tx_flow_char     <= `RST_ZERO;
    end else begin
      flow_state_reg <= flow_state_next;
      if (flow_state_reg == FLOW_IDLE)
        flow_is_stop_reg <= tx_flow_stop;
      tx_flow_valid <= (flow_state_next != FLOW_IDLE);
      case (flow_state_next)
        FLOW_FIRST: begin
          if ((flow_state_reg == FLOW_IDLE ? tx_flow_stop : flow_is_stop_reg))
            tx_flow_char <= (tx_sel == `SEL_PAIR_2) ? stop_char_2_reg : stop_char_1_reg;
          else
            tx_flow_char <= (tx_sel == `SEL_PAIR_2) ? resume_char_2_reg : resume_char_1_reg;
        end
        FLOW_SECOND: tx_flow_char <= flow_is_stop_reg ? stop_char_2_reg : resume_char_2_reg;
        default:     tx_flow_char <= tx_flow_char;
      endcase
    end
  end

  // [R23] prescaler then [R11] divisor and oversample counters
  logic pre_tick, div_tick;
  assign pre_tick = !modem_control_reg[`MCR_PRESCALE] || (pre_count_reg == `PRESCALE_LAST);
  assign div_tick = pre_tick && (divisor_reg != 16'h0000) &&
                    (div_count_reg >= divisor_reg - 16'h0001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count_reg  <= 2'h0;
      div_count_reg  <= 16'h0000;
      over_count_reg <= 4'h0;
      baud16_tick    <= 1'b0;
      baud_tick      <= 1'b0;
    end else begin
      pre_count_reg <= pre_count_reg + 2'h1;
      if (div_tick)
        div_count_reg <= 16'h0000;
      else if (pre_tick)
        div_count_reg <= div_count_reg + 16'h0001;
      if (div_tick)
        over_count_reg <= over_count_reg + 4'h1;
      baud16_tick <= div_tick;
      baud_tick   <= div_tick && (over_count_reg == `OVERSAMPLE_LAST);
    end
  end

endmodule
